// ==== hw/dapc_regs.svh ====
`ifndef DAPC_REGS_SVH
`define DAPC_REGS_SVH

// Register byte addresses.
`define DAPC_ADDR_ANT_CTRL  8'h14
`define DAPC_ADDR_PREAMBLE  8'h18
`define DAPC_ADDR_SCR_TAPS  8'h1c
`define DAPC_ADDR_AMP_HIGH  8'h20
`define DAPC_ADDR_W         8

// Reset values.
`define DAPC_RST_BYTE       8'h00

// Antenna control fields.
`define DAPC_ANT_ACCDLY     4
`define DAPC_ANT_MPATH      3
`define DAPC_ANT_DIV        2
`define DAPC_ANT_MODE_HI    1
`define DAPC_ANT_MODE_LO    0
`define DAPC_MODE_LAST      2'h0
`define DAPC_MODE_B         2'h2
`define DAPC_MODE_A         2'h3

// Scrambler taps register fields.
`define DAPC_SCR_RXCLK      7
`define DAPC_SCR_TAPS_HI    6

// Amplitude high byte carries threshold bits 8 to 14.
`define DAPC_AMP_HIGH_HI    6

// Preamble extension for amplifier ramp-up, in symbols.
`define DAPC_PRE_RAMP       9'h002

// Antenna dwell time and clock period.
`define DAPC_DWELL_NS       16000
`define DAPC_CLK_NS         50
`define DAPC_DWELL_CYC      (`DAPC_DWELL_NS / `DAPC_CLK_NS)

// AXI responses.
`define DAPC_RESP_OKAY      2'h0
`define DAPC_RESP_SLVERR    2'h2

`endif

// ==== hw/dapc_pkg.sv ====
package dapc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ACQ  = 3'h2,
        ST_TX   = 3'h4
    } dapc_state_t;

    typedef struct packed {
        logic [14:0] amplitude;
        logic [15:0] phaseVariance;
    } dapc_meas_t;

    typedef struct packed {
        logic accumDelay;
        logic multipathSelect;
        logic rxClockAlwaysOn;
    } dapc_mode_t;

endpackage

// ==== hw/dapc_cfg.sv ====
`timescale 1ns/100ps
`include "dapc_regs.svh"

// Summary of operation
// RULE1: Accumulation-delay bit delays bit sync accumulation.
// RULE2: Multipath bit selects antenna by multipath metric.
// RULE3: Diversity alternates antennas every 16 us.
// RULE4: Diversity off uses single antenna from mode.
// RULE5: Transmit uses the clear channel antenna.
// RULE6: Mode 00 uses last valid header antenna.
// RULE7: Host never programs antenna mode 01.
// RULE8: Mode 10 selects antenna B, output 0.
// RULE9: Mode 11 selects antenna A, output 1.
// RULE10: Preamble register loads 8-bit preamble counter; the counter here is 9 bits wide.
// RULE11: Host changes preamble only while transmit idle.
// RULE12: Preamble is two symbols longer than count.
// RULE13: Host uses at least 80h dual, 50h single.
// RULE14: Receive clock gated by receive enable unless forced.
// RULE15: Scrambler is 7-bit with seven configurable taps.
// RULE16: Scrambler shifts left each scrambler clock.
// RULE17: High register supplies amplitude threshold bits 8-14.
// RULE18: Amplitude comparison combined with phase variance comparison.
// RULE19: Low byte supplies amplitude threshold bits 0-7.
// RULE20: Sixteen-bit phase variance threshold joins acquisition decision.
// RULE21: Mode 00 records antenna at each valid header; here only headers seen in acquisition are recorded.
module dapc_cfg (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 transmitEnableInput,
    input  wire logic                 receiveEnableInput,
    input  wire logic                 headerValid,
    input  wire logic                 multipathQualityMetric,
    input  wire logic                 symbolTick,
    input  wire logic                 scramblerTick,
    input  wire logic                 scramblerDataIn,
    input  wire logic                 dwellEnd,
    input  wire dapc_pkg::dapc_meas_t measurement,
    input  wire logic [7:0]           ampThresholdLow,
    input  wire logic [15:0]          phaseVarianceThreshold,
    output logic                      antennaSelectOutput,
    output logic                      preambleActive,
    output logic                      scramblerDataOut,
    output logic                      acquisitionDetected,
    output logic                      rxClockEnable,
    output dapc_pkg::dapc_mode_t      modeFlags
);

    logic [7:0]            antCtrl_reg;
    logic [7:0]            preamble_reg;
    logic [7:0]            scrTaps_reg;
    logic [7:0]            ampHigh_reg;
    logic [7:0]            awAddr_reg;
    logic                  awHeld_reg;
    logic [7:0]            wData_reg;
    logic                  wLane_reg;
    logic                  wHeld_reg;
    logic                  doWrite;
    logic                  addrHit;
    logic [7:0]            rdByte;
    logic                  rdHit;
    dapc_pkg::dapc_state_t state_reg;
    dapc_pkg::dapc_state_t state_next;
    logic                  lastGood_reg;
    logic                  ccaAntenna;
    logic [8:0]            dwellCnt_reg;
    logic [8:0]            preambleCnt_reg;
    logic [6:0]            scr_reg;
    logic                  scrFeedback;
    logic [14:0]           ampThreshold;
    logic [1:0]            antMode;
    logic                  diversityOn;

    assign antMode     = antCtrl_reg[`DAPC_ANT_MODE_HI:`DAPC_ANT_MODE_LO];
    assign diversityOn = antCtrl_reg[`DAPC_ANT_DIV];

    // Write address and data may arrive in either order; each is held until both exist.
    assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
    assign doWrite       = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= `DAPC_RST_BYTE;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wHeld_reg <= 1'b0;
            wData_reg <= `DAPC_RST_BYTE;
            wLane_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata[7:0];
            wLane_reg <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld_reg <= 1'b0;
        end
    end

    always_comb begin
        unique case (awAddr_reg)
            `DAPC_ADDR_ANT_CTRL, `DAPC_ADDR_PREAMBLE,
            `DAPC_ADDR_SCR_TAPS, `DAPC_ADDR_AMP_HIGH: addrHit = 1'b1;
            default:                                 addrHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DAPC_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addrHit ? `DAPC_RESP_OKAY : `DAPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Unused upper bits of the antenna control byte are stored and read back but drive no other logic.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            antCtrl_reg  <= `DAPC_RST_BYTE;
            preamble_reg <= `DAPC_RST_BYTE;
            scrTaps_reg  <= `DAPC_RST_BYTE;
            ampHigh_reg  <= `DAPC_RST_BYTE;
        end else if (doWrite && wLane_reg) begin
            unique case (awAddr_reg)
                `DAPC_ADDR_ANT_CTRL: antCtrl_reg  <= wData_reg;
                `DAPC_ADDR_PREAMBLE: preamble_reg <= wData_reg;
                `DAPC_ADDR_SCR_TAPS: scrTaps_reg  <= wData_reg;
                `DAPC_ADDR_AMP_HIGH: ampHigh_reg  <= wData_reg;
                default: ;
            endcase
        end
    end

    always_comb begin
        rdHit  = 1'b1;
        rdByte = `DAPC_RST_BYTE;
        unique case (s_axi_araddr)
            `DAPC_ADDR_ANT_CTRL: rdByte = antCtrl_reg;
            `DAPC_ADDR_PREAMBLE: rdByte = preamble_reg;
            `DAPC_ADDR_SCR_TAPS: rdByte = scrTaps_reg;
            `DAPC_ADDR_AMP_HIGH: rdByte = ampHigh_reg;
            default:             rdHit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `DAPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, rdByte};
            s_axi_rresp  <= rdHit ? `DAPC_RESP_OKAY : `DAPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // RULE1 RULE2 mode outputs
    assign modeFlags.accumDelay      = antCtrl_reg[`DAPC_ANT_ACCDLY];
    assign modeFlags.multipathSelect = antCtrl_reg[`DAPC_ANT_MPATH];
    assign modeFlags.rxClockAlwaysOn = scrTaps_reg[`DAPC_SCR_RXCLK];

    // RULE14 receive clock gate
    assign rxClockEnable = scrTaps_reg[`DAPC_SCR_RXCLK] || receiveEnableInput;

    // Code 01 is undefined; it falls back to the last-header antenna as a safe choice.
    always_comb begin
        unique case (antMode)
            // RULE8 antenna B
            `DAPC_MODE_B: ccaAntenna = 1'b0;
            // RULE9 antenna A
            `DAPC_MODE_A: ccaAntenna = 1'b1;
            // RULE6 RULE7 last header
            default:      ccaAntenna = lastGood_reg;
        endcase
    end

    // Transmit wins over receive so a pending frame never waits on acquisition.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            dapc_pkg::ST_IDLE: begin
                if (transmitEnableInput) begin
                    state_next = dapc_pkg::ST_TX;
                end else if (receiveEnableInput) begin
                    state_next = dapc_pkg::ST_ACQ;
                end
            end
            dapc_pkg::ST_ACQ: begin
                if (!receiveEnableInput || transmitEnableInput) begin
                    state_next = dapc_pkg::ST_IDLE;
                end
            end
            dapc_pkg::ST_TX: begin
                if (!transmitEnableInput) begin
                    state_next = dapc_pkg::ST_IDLE;
                end
            end
            default: state_next = dapc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= dapc_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dwellCnt_reg <= 9'h0;
        end else if (state_reg != dapc_pkg::ST_ACQ
                     || dwellCnt_reg == 9'(`DAPC_DWELL_CYC - 1)) begin
            dwellCnt_reg <= 9'h0;
        end else begin
            dwellCnt_reg <= dwellCnt_reg + 9'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            antennaSelectOutput <= 1'b0;
        end else if (state_reg == dapc_pkg::ST_IDLE) begin
            // RULE4 RULE5 clear channel antenna
            antennaSelectOutput <= ccaAntenna;
        end else if (state_reg == dapc_pkg::ST_ACQ && diversityOn
                     && dwellCnt_reg == 9'(`DAPC_DWELL_CYC - 1)) begin
            // RULE3 dwell alternation
            antennaSelectOutput <= !antennaSelectOutput;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lastGood_reg <= 1'b0;
        end else if (headerValid && state_reg == dapc_pkg::ST_ACQ) begin
            // RULE21 RULE2 header antenna
            lastGood_reg <= modeFlags.multipathSelect ? multipathQualityMetric
                                                      : antennaSelectOutput;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            preambleCnt_reg <= 9'h0;
        end else if (state_reg == dapc_pkg::ST_IDLE && state_next == dapc_pkg::ST_TX) begin
            // RULE10 RULE12 preamble load
            preambleCnt_reg <= {1'b0, preamble_reg} + `DAPC_PRE_RAMP;
        end else if (state_reg != dapc_pkg::ST_TX) begin
            preambleCnt_reg <= 9'h0;
        end else if (symbolTick && preambleCnt_reg != 9'h0) begin
            preambleCnt_reg <= preambleCnt_reg - 9'h1;
        end
    end

    assign preambleActive = preambleCnt_reg != 9'h0;

    // RULE15 tap feedback
    assign scrFeedback = scramblerDataIn
                         ^ (^(scr_reg & scrTaps_reg[`DAPC_SCR_TAPS_HI:0]));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scr_reg          <= 7'h0;
            scramblerDataOut <= 1'b0;
        end else if (scramblerTick) begin
            // RULE16 shift left
            scr_reg          <= {scr_reg[5:0], scrFeedback};
            scramblerDataOut <= scrFeedback;
        end
    end

    // RULE17 RULE19 threshold assembly
    assign ampThreshold = {ampHigh_reg[`DAPC_AMP_HIGH_HI:0], ampThresholdLow};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acquisitionDetected <= 1'b0;
        end else begin
            // RULE18 RULE20 combined decision
            acquisitionDetected <= state_reg == dapc_pkg::ST_ACQ && dwellEnd
                                   && measurement.amplitude > ampThreshold
                                   && measurement.phaseVariance < phaseVarianceThreshold;
        end
    end

endmodule // dapc_cfg

// ==== verification/dapc_cfg_sva.sv ====
`timescale 1ns/100ps
module dapc_chk (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 transmitEnableInput,
    input wire logic                 receiveEnableInput,
    input wire logic                 scramblerTick,
    input wire logic                 dwellEnd,
    input wire logic                 antennaSelectOutput,
    input wire logic                 preambleActive,
    input wire logic                 scramblerDataOut,
    input wire logic                 acquisitionDetected,
    input wire logic                 rxClockEnable,
    input wire dapc_pkg::dapc_mode_t modeFlags
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_rx_clock_gate: assert property (
        !modeFlags.rxClockAlwaysOn |-> rxClockEnable == receiveEnableInput)
        else $error("receive clock gate wrong");
    // The first cycles of a transmission may still carry the acquisition antenna.
    a_tx_ant_hold: assert property (
        transmitEnableInput [*4] |-> $stable(antennaSelectOutput))
        else $error("antenna moved during transmit");
    a_pre_clear: assert property (
        !transmitEnableInput [*3] |-> !preambleActive) else $error("preamble outside transmit");
    a_pre_start: assert property (
        (!transmitEnableInput && !receiveEnableInput) [*2] ##1 transmitEnableInput
        |=> preambleActive) else $error("preamble not started");
    a_scr_hold: assert property (
        !scramblerTick |=> $stable(scramblerDataOut)) else $error("scrambler moved without tick");
    a_acq_cause: assert property (
        acquisitionDetected |-> $past(dwellEnd) && $past(receiveEnableInput, 2))
        else $error("acquisition without dwell");

    c_acq: cover property (acquisitionDetected);
    c_pre_end: cover property ($fell(preambleActive));
    c_rx_forced: cover property (modeFlags.rxClockAlwaysOn && !receiveEnableInput);
endmodule // dapc_chk

bind dapc_cfg dapc_chk u_chk (.*);

// ==== verification/dapc_host.sv ====
`timescale 1ns/100ps
// Host model: one write and one read at most in flight, valid held until taken.
module dapc_host (
    input  wire logic        clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
             s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // dapc_host

// ==== verification/test_dsss_antenna_preamble_scrambler_cfg.sv ====
`timescale 1ns/100ps
`include "dapc_regs.svh"
module test_dsss_antenna_preamble_scrambler_cfg;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, ampThresholdLow;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [15:0] phaseVarianceThreshold;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [6:0]  sr = '0;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        transmitEnableInput, receiveEnableInput, headerValid, multipathQualityMetric;
    logic        symbolTick, scramblerTick, scramblerDataIn, dwellEnd, fb;
    logic        antennaSelectOutput, preambleActive, scramblerDataOut;
    logic        acquisitionDetected, rxClockEnable;
    // Counts respect the recommended minimum for dual antenna use; ff exercises the ninth bit.
    logic [7:0]  preLen [3] = '{8'h80, 8'ha5, 8'hff};
    logic [7:0]  taps [2] = '{8'h48, 8'h05};
    // Bit 31 expected flag, bits 30:16 amplitude, bits 15:0 phase variance.
    logic [31:0] acqCase [4] = '{32'h1234_00ff, 32'h9235_00ff, 32'h1235_0100, 32'h0235_00ff};
    dapc_pkg::dapc_meas_t measurement;
    dapc_pkg::dapc_mode_t modeFlags;
    int          num_errors = 0;
    int          compares = 0;
    int          n;

    dapc_cfg  dut (.*);
    dapc_host host (.*);

    initial begin
        {transmitEnableInput, receiveEnableInput, headerValid, multipathQualityMetric,
         symbolTick, scramblerTick, scramblerDataIn, dwellEnd} = '0;
        {measurement, ampThresholdLow, phaseVarianceThreshold} = '0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ev,
                      input logic [1:0] er = `DAPC_RESP_OKAY);
        host.axiRead(a, rdv, resp);
        chk(rdv, {24'h0, ev});
        chk(resp, er);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er = `DAPC_RESP_OKAY);
        host.axiWrite(a, {24'h0, d}, 4'h1, resp);
        chk(resp, er);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        num_errors++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(`DAPC_ADDR_ANT_CTRL, 8'h00);
        rd(`DAPC_ADDR_PREAMBLE, 8'h00);
        rd(`DAPC_ADDR_SCR_TAPS, 8'h00);
        rd(`DAPC_ADDR_AMP_HIGH, 8'h00);
        rd(8'h24, 8'h00, `DAPC_RESP_SLVERR);
        wr(8'h24, 8'h5a, `DAPC_RESP_SLVERR);
        wr(`DAPC_ADDR_ANT_CTRL, 8'hdb);
        rd(`DAPC_ADDR_ANT_CTRL, 8'hdb);
        wr(`DAPC_ADDR_SCR_TAPS, 8'hc8);
        rd(`DAPC_ADDR_SCR_TAPS, 8'hc8);
        wr(`DAPC_ADDR_AMP_HIGH, 8'h92);
        host.axiWrite(`DAPC_ADDR_AMP_HIGH, 32'h11, 4'h0, resp);
        chk(resp, `DAPC_RESP_OKAY);
        rd(`DAPC_ADDR_AMP_HIGH, 8'h92);
        chk(modeFlags, 3'b111);
        chk(rxClockEnable, 1'b1);
        chk(antennaSelectOutput, 1'b1);
        wr(`DAPC_ADDR_ANT_CTRL, 8'h02);
        settle(2);
        chk(antennaSelectOutput, 1'b0);
        // A header seen while idle must not be recorded.
        wr(`DAPC_ADDR_ANT_CTRL, 8'h08);
        @(posedge clk);
        headerValid <= 1'b1;
        multipathQualityMetric <= 1'b1;
        @(posedge clk);
        headerValid <= 1'b0;
        receiveEnableInput <= 1'b1;
        settle(3);
        chk(antennaSelectOutput, 1'b0);
        @(posedge clk);
        headerValid <= 1'b1;
        @(posedge clk);
        headerValid <= 1'b0;
        receiveEnableInput <= 1'b0;
        settle(3);
        chk(antennaSelectOutput, 1'b1);
        wr(`DAPC_ADDR_ANT_CTRL, 8'h06);
        @(posedge clk);
        receiveEnableInput <= 1'b1;
        settle(10);
        chk(antennaSelectOutput, 1'b0);
        settle(324);
        chk(antennaSelectOutput, 1'b1);
        settle(319);
        chk(antennaSelectOutput, 1'b0);
        @(posedge clk);
        transmitEnableInput <= 1'b1;
        settle(340);
        chk(antennaSelectOutput, 1'b0);
        @(posedge clk);
        transmitEnableInput <= 1'b0;
        receiveEnableInput <= 1'b0;
        symbolTick <= 1'b1;
        foreach (preLen[i]) begin
            wr(`DAPC_ADDR_PREAMBLE, preLen[i]);
            @(posedge clk);
            transmitEnableInput <= 1'b1;
            @(posedge clk);
            n = 0;
            @(negedge clk);
            while (preambleActive === 1'b1 && n < 300) begin
                n++;
                @(negedge clk);
            end
            chk(n, preLen[i] + 2);
            @(posedge clk);
            transmitEnableInput <= 1'b0;
        end
        foreach (taps[i]) begin
            wr(`DAPC_ADDR_SCR_TAPS, taps[i]);
            for (n = 0; n < 12; n++) begin
                @(posedge clk);
                scramblerDataIn <= n[0] ^ n[2];
                scramblerTick <= 1'b1;
                @(posedge clk);
                scramblerTick <= 1'b0;
                fb = n[0] ^ n[2] ^ (^(sr & taps[i][6:0]));
                sr = {sr[5:0], fb};
                @(negedge clk);
                chk(scramblerDataOut, fb);
            end
        end
        chk(rxClockEnable, 1'b0);
        chk(modeFlags, 3'b000);
        @(posedge clk);
        ampThresholdLow <= 8'h34;
        phaseVarianceThreshold <= 16'h0100;
        receiveEnableInput <= 1'b1;
        foreach (acqCase[i]) begin
            @(posedge clk);
            measurement <= acqCase[i][30:0];
            dwellEnd <= 1'b1;
            @(posedge clk);
            dwellEnd <= 1'b0;
            @(negedge clk);
            chk(acquisitionDetected, acqCase[i][31]);
        end
        conclude();
    end
endmodule // test_dsss_antenna_preamble_scrambler_cfg
